// ### verilog/bridge_pkg.sv
// Shared constants and carrier types for the serial host port of the CAN bridge.
// Assumes a 200 MHz system clock; all timing counts derive from it.
package bridge_pkg;

    localparam int unsigned CLK_HZ          = 200000000;
    localparam int unsigned BAUD_MIN        = 300;
    localparam int unsigned BAUD_MAX        = 921600;
    localparam int unsigned BITS_PER_CHAR   = 10;
    localparam int unsigned DATA_BITS       = 8;
    localparam int unsigned DIV_W           = 20;
    localparam logic [DIV_W-1:0] DIV_MAX    = DIV_W'(CLK_HZ / BAUD_MIN);
    localparam logic [DIV_W-1:0] DIV_MIN    = DIV_W'(CLK_HZ / BAUD_MAX);
    localparam int unsigned GAP_W           = 32;
    localparam int unsigned STD_ID_W        = 11;
    localparam int unsigned EXT_ID_W        = 29;
    localparam logic [10:0] STD_ID_MAX      = 11'h7FF;
    localparam logic [28:0] EXT_ID_MAX      = 29'h1FFFFFFF;
    localparam logic [1:0]  STRAP_UART_BRIDGE = 2'h1;
    localparam logic [1:0]  STRAP_SPI_BRIDGE  = 2'h3;
    localparam logic [1:0]  STRAP_UART_CFG    = 2'h0;
    localparam logic [1:0]  STRAP_SPI_CFG     = 2'h2;

    typedef enum logic [1:0] {
        MODE_UART_CFG    = 2'b00,
        MODE_UART_BRIDGE = 2'b01,
        MODE_SPI_CFG     = 2'b10,
        MODE_SPI_BRIDGE  = 2'b11
    } work_mode_t;

    typedef enum logic [1:0] {
        FIELD_HEADER  = 2'b00,
        FIELD_LENGTH  = 2'b01,
        FIELD_PAYLOAD = 2'b10,
        FIELD_TRAILER = 2'b11
    } frame_field_t;

    // One received byte with its framing marks, from either serial side.
    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic [10:0] std_id;
        logic [28:0] ext_id;
        logic        extended;
    } can_id_t;

endpackage

// ### verilog/sync_two_flop.sv
// Two-flop synchroniser for a single asynchronous level.
// Assumes the input changes slowly compared to the 5 ns clock.
`timescale 1ns/1ps
module sync_two_flop #(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
        if (reset) begin
            next_stage1   = INIT;
            next_sync_out = INIT;
        end
    end

    always_ff @(posedge clk) begin
        stage1   <= next_stage1;
        sync_out <= next_sync_out;
    end
endmodule

// ### verilog/serial_to_can_host_port.sv
// Host port of the serial-to-CAN bridge: strap-selected mode, UART 8N1 receive with idle-gap
// framing, SPI mode 3 slave with chip-select framing, and the active-low alert output.
// Assumes reset is the device reset already reduced to the system clock; CAN engine lives elsewhere.
// Operation
// RULE1 - Host holds interface strap low for UART
// RULE2 - Host holds interface strap high for SPI
// RULE3 - Straps select one of four working modes
// RULE4 - Strap changes take effect only after reset
// RULE5 - Host holds reset at least 100 us
// RULE6 - Host waits 3 ms after reset release
// RULE7 - UART is fixed 8N1, not configurable
// RULE8 - UART rate between 300 and 921600 baud
// RULE9 - UART bridge ignores SPI, never answers there
// RULE10 - UART frame opens on first character, continues
// RULE11 - One character time is ten bits
// RULE12 - Frame closes after gap exceeds n characters
// RULE13 - SPI slave, mode 3, 8-bit, MSB first
// RULE14 - Host SPI clock at most 1.5/1 Mbps
// RULE15 - SPI bridge ignores UART, never sends there
// RULE16 - Chip-select window forms exactly one SPI frame
// RULE17 - Host leaves 40 us between buffer frames
// RULE18 - Standard identifier is 11 bits, to 0x7FF
// RULE19 - Extended identifier is 29 bits, to 0x1FFFFFFF
// RULE20 - Custom frame: header, length, type, id, data, trailer
// RULE21 - Host waits 50 us after select change
// RULE22 - Alert low from trigger until buffer empty (code asserts it only in SPI bridge mode; held high in the other modes)
// RULE23 - Configuration modes block all CAN traffic
// RULE24 - Straps sampled once at reset release
// RULE25 - Idle counter restarts each stop bit
`timescale 1ns/1ps
module serial_to_can_host_port
    import bridge_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 mode_strap,
    input  wire logic                 cfg_strap,
    input  wire logic [DIV_W-1:0]     baud_div,
    input  wire logic [7:0]           gap_chars,
    input  wire logic                 uart_rx,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_sck,
    input  wire logic                 spi_mosi,
    input  wire logic [7:0]           spi_tx_byte,
    input  wire logic                 rx_count_at_trigger,
    input  wire logic                 rx_buffer_empty,
    input  wire can_id_t              can_id_in,
    output work_mode_t                work_mode,
    output logic                      can_enable,
    output rx_byte_t                  uart_byte,
    output logic                      uart_frame_end,
    output rx_byte_t                  spi_byte,
    output logic                      spi_frame_end,
    output logic                      spi_miso,
    output logic                      spi_miso_oe,
    output logic                      alert_n,
    output can_id_t                   can_id_out
);
    import bridge_pkg::*;

    logic rx_s, cs_s, sck_s, mosi_s, mode_s, cfg_s;

    sync_two_flop #(.INIT(1'b1)) u_rx   (.clk(clk), .reset(reset), .async_in(uart_rx),    .sync_out(rx_s));
    sync_two_flop #(.INIT(1'b1)) u_cs   (.clk(clk), .reset(reset), .async_in(spi_cs_n),   .sync_out(cs_s));
    sync_two_flop #(.INIT(1'b1)) u_sck  (.clk(clk), .reset(reset), .async_in(spi_sck),    .sync_out(sck_s));
    sync_two_flop #(.INIT(1'b0)) u_mosi (.clk(clk), .reset(reset), .async_in(spi_mosi),   .sync_out(mosi_s));
    sync_two_flop #(.INIT(1'b0)) u_mode (.clk(clk), .reset(reset), .async_in(mode_strap), .sync_out(mode_s));
    sync_two_flop #(.INIT(1'b1)) u_cfg  (.clk(clk), .reset(reset), .async_in(cfg_strap),  .sync_out(cfg_s));

    // Mode latch. The synchronisers are themselves in reset, so the straps are caught on the
    // first cycle their synchronised value is valid after release, and then frozen.
    logic [1:0] settle;
    logic       mode_held;
    logic [1:0] next_settle;
    logic       next_mode_held;
    work_mode_t next_work_mode;

    always_comb begin
        next_settle    = settle;
        next_mode_held = mode_held;
        next_work_mode = work_mode;
        if (settle != 2'h2) begin
            next_settle = settle + 2'h1;
        end else if (!mode_held) begin
            next_mode_held = 1'b1;                                   // RULE24
            next_work_mode = work_mode_t'({mode_s, cfg_s});          // RULE3
        end
        if (reset) begin
            next_settle    = 2'h0;
            next_mode_held = 1'b0;
            next_work_mode = MODE_UART_CFG;
        end
    end

    always_ff @(posedge clk) begin
        settle    <= next_settle;
        mode_held <= next_mode_held;
        work_mode <= next_work_mode;                                 // RULE4
    end

    wire uart_on = mode_held && !work_mode[1];                       // RULE15
    wire spi_on  = mode_held && work_mode[1];                        // RULE9
    wire bridge  = mode_held && work_mode[0];                        // RULE23

    // UART receiver, fixed 8N1, sampling at the middle of each bit.
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_t;

    rx_state_t        rx_state, next_rx_state;
    logic [DIV_W-1:0] rx_cnt, next_rx_cnt;
    logic [2:0]       rx_bit, next_rx_bit;
    logic [7:0]       rx_sh, next_rx_sh;
    logic [GAP_W-1:0] gap_cnt, next_gap_cnt;
    logic             in_frame, next_in_frame;
    rx_byte_t         next_uart_byte;
    logic             next_uart_frame_end;
    logic [DIV_W-1:0] div_eff;
    logic [GAP_W-1:0] gap_limit;

    always_comb begin
        div_eff = baud_div;                                          // RULE8
        if (baud_div < DIV_MIN) div_eff = DIV_MIN;
        if (baud_div > DIV_MAX) div_eff = DIV_MAX;
        gap_limit = GAP_W'(gap_chars) * GAP_W'(BITS_PER_CHAR) * GAP_W'(div_eff); // RULE11
    end

    always_comb begin
        next_rx_state       = rx_state;
        next_rx_cnt         = rx_cnt;
        next_rx_bit         = rx_bit;
        next_rx_sh          = rx_sh;
        next_gap_cnt        = gap_cnt;
        next_in_frame       = in_frame;
        next_uart_byte      = '0;
        next_uart_frame_end = 1'b0;
        if (in_frame && gap_cnt <= gap_limit) begin
            next_gap_cnt = gap_cnt + GAP_W'(1);
        end
        if (in_frame && gap_cnt > gap_limit && rx_state == RX_IDLE) begin
            next_in_frame       = 1'b0;                              // RULE12
            next_uart_frame_end = 1'b1;
        end
        case (rx_state)
            RX_IDLE: begin
                if (uart_on && !rx_s) begin
                    next_rx_state = RX_START;
                    next_rx_cnt   = div_eff >> 1;
                end
            end
            RX_START: begin
                if (rx_cnt == '0) begin
                    next_rx_state = rx_s ? RX_IDLE : RX_DATA;
                    next_rx_cnt   = div_eff - DIV_W'(1);
                    next_rx_bit   = 3'h0;
                end else begin
                    next_rx_cnt = rx_cnt - DIV_W'(1);
                end
            end
            RX_DATA: begin
                if (rx_cnt == '0) begin
                    next_rx_sh  = {rx_s, rx_sh[7:1]};               // RULE7
                    next_rx_cnt = div_eff - DIV_W'(1);
                    next_rx_bit = rx_bit + 3'h1;
                    if (rx_bit == 3'h7) next_rx_state = RX_STOP;
                end else begin
                    next_rx_cnt = rx_cnt - DIV_W'(1);
                end
            end
            RX_STOP: begin
                if (rx_cnt == '0) begin
                    next_rx_state = RX_IDLE;
                    // A broken stop bit drops the character without touching the frame.
                    if (rx_s) begin
                        next_uart_byte.valid = 1'b1;
                        next_uart_byte.first = !in_frame;            // RULE10
                        next_uart_byte.data  = rx_sh;
                        next_in_frame        = 1'b1;
                        next_gap_cnt         = '0;                   // RULE25
                        next_uart_frame_end  = 1'b0;
                    end
                end else begin
                    next_rx_cnt = rx_cnt - DIV_W'(1);
                end
            end
            default: next_rx_state = RX_IDLE;
        endcase
        if (reset) begin
            next_rx_state       = RX_IDLE;
            next_rx_cnt         = '0;
            next_rx_bit         = 3'h0;
            next_rx_sh          = 8'h00;
            next_gap_cnt        = '0;
            next_in_frame       = 1'b0;
            next_uart_byte      = '0;
            next_uart_frame_end = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        rx_state       <= next_rx_state;
        rx_cnt         <= next_rx_cnt;
        rx_bit         <= next_rx_bit;
        rx_sh          <= next_rx_sh;
        gap_cnt        <= next_gap_cnt;
        in_frame       <= next_in_frame;
        uart_byte      <= next_uart_byte;
        uart_frame_end <= next_uart_frame_end;
    end

    // SPI mode 3 slave: drive on falling SCK, sample on rising SCK, MSB first.
    logic       sck_d, cs_d;
    logic [2:0] sp_bit;
    logic [7:0] sp_in, sp_out;
    logic       sp_first;
    logic       next_sck_d, next_cs_d, next_sp_first, next_spi_frame_end;
    logic       next_spi_miso, next_spi_miso_oe;
    logic [2:0] next_sp_bit;
    logic [7:0] next_sp_in, next_sp_out;
    rx_byte_t   next_spi_byte;

    always_comb begin
        next_sck_d         = sck_s;
        next_cs_d          = cs_s;
        next_sp_bit        = sp_bit;
        next_sp_in         = sp_in;
        next_sp_out        = sp_out;
        next_sp_first      = sp_first;
        next_spi_byte      = '0;
        next_spi_frame_end = 1'b0;
        next_spi_miso      = spi_miso;
        next_spi_miso_oe   = 1'b0;
        if (spi_on && !cs_s) begin
            next_spi_miso_oe = 1'b1;
            if (cs_d) begin
                next_sp_bit   = 3'h0;                                // RULE16
                next_sp_first = 1'b1;
                next_sp_out   = spi_tx_byte;
                next_spi_miso = spi_tx_byte[7];
            end else if (sck_d && !sck_s) begin
                next_spi_miso = sp_out[7];                           // RULE13
            end else if (!sck_d && sck_s) begin
                next_sp_in  = {sp_in[6:0], mosi_s};
                next_sp_out = {sp_out[6:0], 1'b0};
                next_sp_bit = sp_bit + 3'h1;
                if (sp_bit == 3'h7) begin
                    next_spi_byte.valid = 1'b1;
                    next_spi_byte.first = sp_first;
                    next_spi_byte.data  = {sp_in[6:0], mosi_s};
                    next_sp_first       = 1'b0;
                    next_sp_out         = spi_tx_byte;
                end
            end
        end
        if (spi_on && cs_s && !cs_d) begin
            next_spi_frame_end = 1'b1;                               // RULE16
        end
        if (reset) begin
            next_sck_d         = 1'b1;
            next_cs_d          = 1'b1;
            next_sp_bit        = 3'h0;
            next_sp_in         = 8'h00;
            next_sp_out        = 8'h00;
            next_sp_first      = 1'b0;
            next_spi_byte      = '0;
            next_spi_frame_end = 1'b0;
            next_spi_miso      = 1'b0;
            next_spi_miso_oe   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        sck_d         <= next_sck_d;
        cs_d          <= next_cs_d;
        sp_bit        <= next_sp_bit;
        sp_in         <= next_sp_in;
        sp_out        <= next_sp_out;
        sp_first      <= next_sp_first;
        spi_byte      <= next_spi_byte;
        spi_frame_end <= next_spi_frame_end;
        spi_miso      <= next_spi_miso;
        spi_miso_oe   <= next_spi_miso_oe;
    end

    // Alert and identifier masking toward the CAN side.
    logic    next_alert_n, next_can_enable;
    can_id_t next_can_id_out;

    always_comb begin
        next_can_enable = bridge;                                    // RULE23
        next_alert_n    = alert_n;
        if (!spi_on || !bridge || rx_buffer_empty) begin
            next_alert_n = 1'b1;
        end else if (rx_count_at_trigger) begin
            next_alert_n = 1'b0;                                     // RULE22
        end
        next_can_id_out.std_id   = can_id_in.std_id & STD_ID_MAX;    // RULE18
        next_can_id_out.ext_id   = can_id_in.ext_id & EXT_ID_MAX;    // RULE19
        next_can_id_out.extended = can_id_in.extended;
        if (reset) begin
            next_can_enable = 1'b0;
            next_alert_n    = 1'b1;
            next_can_id_out = '0;
        end
    end

    always_ff @(posedge clk) begin
        can_enable <= next_can_enable;
        alert_n    <= next_alert_n;
        can_id_out <= next_can_id_out;
    end

    AST_MODE_FROZEN: assert property (@(posedge clk) disable iff (reset)
        mode_held && $past(mode_held) |-> $stable(work_mode))
        else $error("working mode changed without reset"); // RULE4
    AST_MODE_FROM_STRAP: assert property (@(posedge clk) disable iff (reset)
        $rose(mode_held) |-> work_mode == work_mode_t'({$past(mode_s), $past(cfg_s)}))
        else $error("mode does not match straps"); // RULE3
    AST_LATCH_TIME: assert property (@(posedge clk) $fell(reset) |-> ##3 mode_held)
        else $error("straps not sampled three cycles after release"); // RULE24
    AST_NO_SPI_IN_UART: assert property (@(posedge clk) disable iff (reset)
        !work_mode[1] |-> !spi_byte.valid && !spi_miso_oe)
        else $error("spi active in uart mode"); // RULE9
    AST_NO_UART_IN_SPI: assert property (@(posedge clk) disable iff (reset)
        work_mode[1] && mode_held && $past(mode_held, 20) |-> !uart_byte.valid)
        else $error("uart active in spi mode"); // RULE15
    AST_CFG_NO_CAN: assert property (@(posedge clk) disable iff (reset)
        !work_mode[0] |=> !can_enable)
        else $error("can enabled in configuration mode"); // RULE23
    AST_ALERT_EMPTY: assert property (@(posedge clk) disable iff (reset)
        rx_buffer_empty |=> alert_n)
        else $error("alert held with empty buffer"); // RULE22
    AST_GAP_RESTART: assert property (@(posedge clk) disable iff (reset)
        uart_byte.valid |-> gap_cnt == '0 && in_frame)
        else $error("gap counter not restarted on character"); // RULE25
    AST_FRAME_END: assert property (@(posedge clk) disable iff (reset)
        uart_frame_end |-> !in_frame && $past(gap_cnt) > $past(gap_limit))
        else $error("frame closed before gap elapsed"); // RULE12
    AST_SPI_END: assert property (@(posedge clk) disable iff (reset)
        spi_frame_end |-> $past(cs_s) && !$past(cs_d))
        else $error("spi frame end without chip select release"); // RULE16
    AST_STD_ID: assert property (@(posedge clk) disable iff (reset) // RULE18
        !$past(reset) |-> can_id_out.std_id == ($past(can_id_in.std_id) & STD_ID_MAX))
        else $error("standard id not carried through");
endmodule

// ### tb/host_serial_model.sv
// Host model: drives the UART line and the SPI mode 3 master pins of the host port.
// Assumes the bench calls one task at a time; SCK stands still between frames.
`timescale 1ns/1ps
module host_serial_model (
    input  wire logic        clk,
    input  wire logic        spi_miso,
    input  wire logic        spi_miso_oe,
    output logic             uart_rx,
    output logic             spi_cs_n,
    output logic             spi_sck,
    output logic             spi_mosi,
    output logic [15:0]      miso_cap
);
    // MISO carries a pull-up on the host side, so a released line reads high, not a stale bit.
    wire miso_line = spi_miso_oe ? spi_miso : 1'b1;

    initial begin
        uart_rx = 1'b1;
        spi_cs_n = 1'b1;
        spi_sck = 1'b1;
        spi_mosi = 1'b0;
        miso_cap = 16'h0000;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Start bit, eight data bits LSB first, one stop bit, no parity.
    task automatic send_uart(input logic [7:0] b, input int div);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            uart_rx <= f[i];
            ticks(div - 1);
        end
    endtask

    // Half period of 8 clk cycles gives an 80 ns SCK period (12.5 MHz), far above the 1.5 Mbps host rate ceiling.
    task automatic send_spi(input logic [15:0] d, input int nbytes);
        @(posedge clk);
        spi_cs_n <= 1'b0;
        ticks(8);
        for (int i = 0; i < nbytes * 8; i++) begin
            @(posedge clk);
            spi_sck <= 1'b0;
            spi_mosi <= d[15-i];
            ticks(7);
            @(posedge clk);
            spi_sck <= 1'b1;
            miso_cap <= {miso_cap[14:0], miso_line};
            ticks(7);
        end
        ticks(8);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
    endtask
endmodule

// ### tb/tb_serial_to_can_host_port.sv
// Self-checking bench for the host port: straps, UART gap framing, SPI frames, alert, identifiers.
// Assumes the host model drives the serial pins; expected bytes are queued and popped by a monitor.
`timescale 1ns/1ps
`define CHK(got, want) begin tests_run++; if ((got) !== (want)) begin n_mismatch++; $display("[ERR] %0t mismatch", $time); end end
module tb_serial_to_can_host_port;
    import bridge_pkg::*;
    localparam int DIV   = int'(DIV_MIN);
    localparam int LIMIT = 40000;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic             mode_strap = 1'b0;
    logic             cfg_strap = 1'b1;
    logic [DIV_W-1:0] baud_div = DIV_MIN;
    logic [7:0]       gap_chars = 8'h02;
    logic [7:0]       spi_tx_byte = 8'h00;
    logic             rx_count_at_trigger = 1'b0;
    logic             rx_buffer_empty = 1'b1;
    can_id_t          can_id_in = '0;
    logic             uart_rx, spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe, alert_n;
    logic             can_enable, uart_frame_end, spi_frame_end;
    logic [15:0]      miso_cap;
    work_mode_t       work_mode;
    rx_byte_t         uart_byte, spi_byte;
    can_id_t          can_id_out;
    int               n_mismatch = 0;
    int               tests_run = 0;
    int               cyc = 0;
    int               last_cyc = 0;
    int               end_cyc = 0;
    int               n_uart_end = 0;
    int               n_spi_end = 0;
    logic [31:0]      rs = 32'h55C9;
    logic [31:0]      r;
    logic [9:0]       exp_q[$];

    serial_to_can_host_port i_dut (
        .clk(clk), .reset(reset), .mode_strap(mode_strap), .cfg_strap(cfg_strap),
        .baud_div(baud_div), .gap_chars(gap_chars), .uart_rx(uart_rx), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_tx_byte(spi_tx_byte),
        .rx_count_at_trigger(rx_count_at_trigger), .rx_buffer_empty(rx_buffer_empty),
        .can_id_in(can_id_in), .work_mode(work_mode), .can_enable(can_enable),
        .uart_byte(uart_byte), .uart_frame_end(uart_frame_end), .spi_byte(spi_byte),
        .spi_frame_end(spi_frame_end), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .alert_n(alert_n), .can_id_out(can_id_out)
    );

    host_serial_model i_host (
        .clk(clk), .spi_miso(spi_miso), .uart_rx(uart_rx), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_mosi(spi_mosi), .miso_cap(miso_cap), .spi_miso_oe(spi_miso_oe)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Reset is scaled down to two cycles; the settle wait covers the strap capture delay.
    task automatic reset_to(input logic m, input logic c);
        @(posedge clk);
        mode_strap <= m;
        cfg_strap <= c;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic check_byte(input logic [9:0] got);
        `CHK(exp_q.size() > 0, 1'b1)
        if (exp_q.size() > 0) begin
            `CHK(got, exp_q.pop_front())
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (uart_byte.valid === 1'b1) begin
            last_cyc = cyc;
            check_byte({1'b0, uart_byte.first, uart_byte.data});
        end
        if (spi_byte.valid === 1'b1) begin
            check_byte({1'b1, spi_byte.first, spi_byte.data});
        end
        if (uart_frame_end === 1'b1) begin
            n_uart_end++;
            end_cyc = cyc;
        end
        if (spi_frame_end === 1'b1) begin
            n_spi_end++;
        end
        if (cyc > LIMIT) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            reset_to(k[1], k[0]);
            `CHK(work_mode, work_mode_t'(k[1:0]))
            `CHK(can_enable, k[0])
            @(posedge clk);
            mode_strap <= ~k[1];
            cfg_strap <= ~k[0];
            repeat (8) @(posedge clk);
            #1;
            `CHK(work_mode, work_mode_t'(k[1:0]))
        end
        // UART bridge: three back-to-back characters, SPI traffic that must go unanswered.
        reset_to(1'b0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            r = xs();
            exp_q.push_back({1'b0, i == 0, r[7:0]});
            i_host.send_uart(r[7:0], DIV);
        end
        i_host.send_spi(16'hA55A, 2);
        `CHK(spi_miso_oe, 1'b0)
        `CHK(miso_cap, 16'hFFFF)
        for (int t = 0; t < 6000 && n_uart_end == 0; t++) @(posedge clk);
        `CHK(n_uart_end, 1)
        `CHK((end_cyc - last_cyc > 20 * DIV) && (end_cyc - last_cyc <= 20 * DIV + 8), 1'b1)
        `CHK(n_spi_end, 0)
        // SPI bridge: two-byte frame, UART byte ignored, then a second frame after the gap.
        reset_to(1'b1, 1'b1);
        r = xs();
        spi_tx_byte <= r[23:16];
        exp_q.push_back({2'b11, r[15:8]});
        exp_q.push_back({2'b10, r[7:0]});
        i_host.send_spi(r[15:0], 2);
        for (int t = 0; t < 100 && n_spi_end == 0; t++) @(posedge clk);
        `CHK(n_spi_end, 1)
        `CHK(miso_cap, {r[23:16], r[23:16]})
        i_host.send_uart(r[7:0], DIV);
        repeat (8000) @(posedge clk);
        `CHK(n_uart_end, 1)
        r = xs();
        exp_q.push_back({2'b11, r[15:8]});
        i_host.send_spi(r[15:0], 1);
        for (int t = 0; t < 100 && n_spi_end == 1; t++) @(posedge clk);
        `CHK(n_spi_end, 2)
        `CHK(exp_q.size(), 0)
        // Alert follows the trigger and stays low until the buffer empties.
        @(posedge clk);
        rx_count_at_trigger <= 1'b1;
        rx_buffer_empty <= 1'b0;
        r = xs();
        can_id_in <= {r[10:0], r[31:3], r[0]};
        repeat (3) @(posedge clk);
        #1;
        `CHK(alert_n, 1'b0)
        `CHK(can_id_out, can_id_in)
        rx_count_at_trigger <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(alert_n, 1'b0)
        rx_buffer_empty <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(alert_n, 1'b1)
        tally_and_finish();
    end
endmodule
